// ---- design/qhp_regs.svh ----
`ifndef QHP_REGS_SVH
`define QHP_REGS_SVH

// ----------------------------------------------------------------
// register offsets on the 3-bit channel address
// ----------------------------------------------------------------
`define QHP_FCR_ADDR 3'h2
`define QHP_MCR_ADDR 3'h4
`define QHP_LSR_ADDR 3'h5
`define QHP_FIFO_READY_SUMMARY_REG_ADDR 3'h7

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define QHP_FCR_FIFO_EN_BIT 0
`define QHP_FCR_BLOCK_BIT 3
`define QHP_MCR_IRQ_EN_BIT 3
`define QHP_MCR_XON_ANY_BIT 5
`define QHP_MCR_PRESCALE_BIT 7
`define QHP_LSR_THR_ROOM_BIT 5
`define QHP_LSR_TX_EMPTY_BIT 6
`define QHP_MCR_RESET 8'h00
`define QHP_FCR_RESET 8'h00
`define QHP_FIFO_DEPTH 7'h40

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define QHP_CLK_NS 10
`define QHP_RESET_NS 40
`define QHP_RESET_CYC ((`QHP_RESET_NS + `QHP_CLK_NS - 1) / `QHP_CLK_NS)
`define QHP_RESET_CNT_W 3
`define QHP_STRAP_DLY 2'h3
`define QHP_STRAP_LOAD 2'h1

// ----------------------------------------------------------------
// pin synchroniser width and idle pattern
// ----------------------------------------------------------------
`define QHP_SYNC_W 25
`define QHP_SYNC_INIT 25'h11FE000

`endif

// ---- design/qhp_pkg.sv ----
package qhp_pkg;
   typedef enum logic {QHP_RW_BUS, QHP_STROBE_BUS} qhp_bus_type;
   typedef enum {QHP_IDLE, QHP_WRITE, QHP_READ} qhp_cycle_type;
   typedef logic [6:0] qhp_level_type;
endpackage : qhp_pkg

// ---- design/qhp_chan_if.sv ----
`timescale 1ns/1ps
interface qhp_chan_if;
   import qhp_pkg::*;
   logic fifo_en;
   logic block_mode;
   logic rx_timeout;
   logic tx_shift_empty;
   qhp_level_type tx_count;
   qhp_level_type rx_count;
   qhp_level_type tx_trig;
   qhp_level_type rx_trig;
   logic tx_int;
   logic rx_int;
   logic tx_ready_n;
   logic rx_ready_n;
   logic lsr_room;
   logic lsr_empty;
   modport ctl (output fifo_en, block_mode, rx_timeout, tx_shift_empty, tx_count, rx_count,
      tx_trig, rx_trig, input tx_int, rx_int, tx_ready_n, rx_ready_n, lsr_room, lsr_empty);
   modport stat (input fifo_en, block_mode, rx_timeout, tx_shift_empty, tx_count, rx_count,
      tx_trig, rx_trig, output tx_int, rx_int, tx_ready_n, rx_ready_n, lsr_room, lsr_empty);
endinterface : qhp_chan_if

// ---- design/qhp_sync.sv ----
`timescale 1ns/1ps
module qhp_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg;

   // ----------------------------------------------------------------
   // two flops; reset to the idle pin pattern so no false cycle appears
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta_reg <= INIT;
         q <= INIT;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule : qhp_sync

// ---- design/qhp_chan_status.sv ----
`timescale 1ns/1ps
`include "qhp_regs.svh"
module qhp_chan_status
   import qhp_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   qhp_chan_if.stat ch
);
   logic tx_empty;
   logic rx_empty;
   logic blk;

   assign tx_empty = (ch.tx_count == '0);
   assign rx_empty = (ch.rx_count == '0);
   assign blk = ch.fifo_en && ch.block_mode;

   // ----------------------------------------------------------------
   // interrupt levels
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ch.tx_int <= 1'b1;
         ch.rx_int <= 1'b0;
      end else begin
         ch.tx_int <= ch.fifo_en ? (ch.tx_count <= ch.tx_trig) : tx_empty;
         ch.rx_int <= ch.fifo_en ? (ch.rx_count >= ch.rx_trig) : !rx_empty;
      end
   end

   // ----------------------------------------------------------------
   // ready pins
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ch.rx_ready_n <= 1'b1;
      end else if (blk) begin
         if (rx_empty) begin
            ch.rx_ready_n <= 1'b1;
         end else if (ch.rx_count >= ch.rx_trig || ch.rx_timeout) begin
            ch.rx_ready_n <= 1'b0;
         end
      end else begin
         ch.rx_ready_n <= rx_empty;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ch.tx_ready_n <= 1'b0;
      end else begin
         ch.tx_ready_n <= blk ? (ch.tx_count == `QHP_FIFO_DEPTH) : !tx_empty;
      end
   end

   // ----------------------------------------------------------------
   // transmitter status bits
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ch.lsr_room <= 1'b1;
         ch.lsr_empty <= 1'b1;
      end else begin
         ch.lsr_room <= ch.fifo_en ? (ch.tx_count < `QHP_FIFO_DEPTH) : tx_empty;
         ch.lsr_empty <= tx_empty && ch.tx_shift_empty;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   AST_RX_BLOCK_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
      (blk && !ch.rx_ready_n && !rx_empty) ##1 (blk && !rx_empty) |-> !ch.rx_ready_n)
      else $error("block mode receive ready rose before the fifo emptied");
   AST_TX_BLOCK_FULL: assert property (@(posedge clk) disable iff (!rst_n)
      (blk && ch.tx_count == `QHP_FIFO_DEPTH) |=> ch.tx_ready_n)
      else $error("block mode transmit ready low with a full fifo");
   AST_RX_SINGLE: assert property (@(posedge clk) disable iff (!rst_n)
      (ch.fifo_en && !ch.block_mode && !rx_empty) |=> !ch.rx_ready_n)
      else $error("receive ready high while the fifo holds data");
   AST_TX_INT_NOFIFO: assert property (@(posedge clk) disable iff (!rst_n)
      (!ch.fifo_en && !tx_empty) [*2] |-> !ch.tx_int)
      else $error("transmit interrupt high while the holding register is full");
endmodule : qhp_chan_status

// ---- design/qhp_host_port.sv ----
`timescale 1ns/1ps
`include "qhp_regs.svh"
// Function
// - modem control bit 5 lets any received character resume software-paused transmit.
// - strobe style: interrupt always driven if mode pin high, else by modem control bit 3.
// - prescaler default comes from the select pin; modem control bit 7 overrides.
// - one status register shows all four transmit and receive ready pins, registered one clock behind them.
// - one shared 8-bit data bus with 3 address lines and read/write controls.
// - host cycles are qualified by selects and strobes alone, no baud clock.
// - strobe style: high reset pulse over 40 ns resets registers and serial outputs.
// - bus-style pin high selects strobe style, low selects read/write-line style.
// - strobe style: each channel has its own low select; all high selects none.
// - writes with several selects low go to every selected channel.
// - read/write-line style: two extra address bits pick channel A to D.
// - fifo: transmit interrupt high at or below trigger, low above it.
// - no fifo: receive interrupt high when a byte is held, low otherwise.
// - fifo: receive interrupt high at or above trigger, low below it.
// - fifo control bit 3 picks single-character or block transfer mode.
// - line status bit 5 flags transmit room, bit 6 transmitter fully empty.
// - no fifo: receive ready low while a byte is held, high otherwise.
// - fifo, single mode: receive ready low while the fifo is not empty.
// - block mode: receive ready falls on trigger or timeout, rises when emptied.
// - block mode: transmit ready low while room remains, high when full.
// - read/write-line style: reset pin is active low, same 40 ns pulse.
module qhp_host_port
   import qhp_pkg::*;
(
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic BUS_STYLE_SEL,
   input wire logic RESET_PIN,
   input wire logic IRQ_MODE_SELECT_IN,
   input wire logic PRESCALER_DEFAULT_SELECT_IN,
   input wire logic CHAN_A_SELECT_N,
   input wire logic CHAN_B_SELECT_N,
   input wire logic CHAN_C_SELECT_N,
   input wire logic CHAN_D_SELECT_N,
   input wire logic CS_N,
   input wire logic RW_N,
   input wire logic READ_STROBE_N,
   input wire logic WRITE_STROBE_N,
   input wire logic [1:0] ADDR_HI,
   input wire logic [2:0] ADDR,
   input wire logic [7:0] DATA_IN,
   output logic [7:0] DATA_OUT,
   output logic DATA_OE,
   output logic [3:0] IRQ_OUT,
   output logic [3:0] IRQ_OE,
   output logic [3:0] TX_READY_N,
   output logic [3:0] RX_READY_N,
   output logic [7:0] FIFO_READY_SUMMARY,
   output logic [3:0] XON_ANY_ENABLE,
   output logic [3:0] PRESCALE_DIV4,
   output logic SERIAL_RESET,
   output logic [2:0] CORE_ADDR,
   output logic [7:0] CORE_WDATA,
   output logic [3:0] CORE_WR_PULSE,
   output logic [3:0] CORE_RD_PULSE,
   input wire logic [27:0] TX_COUNT,
   input wire logic [27:0] RX_COUNT,
   input wire logic [27:0] TX_TRIG,
   input wire logic [27:0] RX_TRIG,
   input wire logic [3:0] RX_TIMEOUT,
   input wire logic [3:0] TX_SHIFT_EMPTY,
   input wire logic [31:0] CORE_RD_DATA
);
   logic [`QHP_SYNC_W-1:0] raw;
   logic [`QHP_SYNC_W-1:0] syn;
   logic style_s;
   logic rst_pin_s;
   logic irq_mode_s;
   logic pre_sel_s;
   logic [3:0] cs4_n_s;
   logic cs_n_s;
   logic rw_n_s;
   logic rd_n_s;
   logic wr_n_s;
   logic [1:0] addr_hi_s;
   logic [2:0] addr_s;
   logic [7:0] data_s;
   qhp_bus_type bus_style;
   logic strobe_bus;
   logic pin_active;
   logic pin_reset;
   logic core_rst_n;
   logic [`QHP_RESET_CNT_W-1:0] rst_cnt_reg;
   logic [1:0] strap_cnt_reg;
   logic strap_load;
   logic [3:0] sel_vec;
   logic wr_act;
   logic rd_act;
   logic commit;
   logic [1:0] rd_idx;
   qhp_cycle_type state_reg;
   logic [3:0] wr_sel_reg;
   logic [2:0] addr_reg;
   logic [7:0] wdata_reg;
   logic [1:0] rd_idx_reg;
   logic [7:0] mcr_reg [4];
   logic [7:0] fcr_reg [4];
   logic [3:0] tx_rdy_n;
   logic [3:0] rx_rdy_n;
   logic [3:0] tx_int;
   logic [3:0] rx_int;
   logic [3:0] lsr_room;
   logic [3:0] lsr_empty;
   logic [7:0] rd_mux;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   assign raw = {BUS_STYLE_SEL, RESET_PIN, IRQ_MODE_SELECT_IN, PRESCALER_DEFAULT_SELECT_IN,
      CHAN_D_SELECT_N, CHAN_C_SELECT_N, CHAN_B_SELECT_N, CHAN_A_SELECT_N, CS_N, RW_N,
      READ_STROBE_N, WRITE_STROBE_N, ADDR_HI, ADDR, DATA_IN};

   qhp_sync #(.W(`QHP_SYNC_W), .INIT(`QHP_SYNC_INIT)) u_sync (
      .clk(CLK),
      .rst_n(RSTN),
      .d(raw),
      .q(syn)
   );

   assign {style_s, rst_pin_s, irq_mode_s, pre_sel_s, cs4_n_s, cs_n_s, rw_n_s, rd_n_s,
      wr_n_s, addr_hi_s, addr_s, data_s} = syn;

   assign bus_style = style_s ? QHP_STROBE_BUS : QHP_RW_BUS;
   assign strobe_bus = (bus_style == QHP_STROBE_BUS);

   // ----------------------------------------------------------------
   // reset pin filter; polarity follows the bus style
   // ----------------------------------------------------------------
   assign pin_active = strobe_bus ? rst_pin_s : !rst_pin_s;

   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         rst_cnt_reg <= '0;
      end else if (!pin_active) begin
         rst_cnt_reg <= '0;
      end else if (rst_cnt_reg != `QHP_RESET_CNT_W'(`QHP_RESET_CYC)) begin
         rst_cnt_reg <= rst_cnt_reg + `QHP_RESET_CNT_W'(1);
      end
   end

   // count holds one cycle past a pulse of exactly the minimum length
   assign pin_reset = (rst_cnt_reg == `QHP_RESET_CNT_W'(`QHP_RESET_CYC));
   assign core_rst_n = RSTN && !pin_reset;

   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         SERIAL_RESET <= 1'b0;
      end else begin
         SERIAL_RESET <= pin_reset;
      end
   end

   // waits for the synchroniser to carry the real strap level
   always_ff @(posedge CLK) begin
      if (!core_rst_n) begin
         strap_cnt_reg <= `QHP_STRAP_DLY;
      end else if (strap_cnt_reg != 2'h0) begin
         strap_cnt_reg <= strap_cnt_reg - 2'h1;
      end
   end

   assign strap_load = (strap_cnt_reg == `QHP_STRAP_LOAD);

   // ----------------------------------------------------------------
   // channel decode
   // ----------------------------------------------------------------
   always_comb begin
      if (strobe_bus) begin
         sel_vec = ~cs4_n_s;
      end else if (cs_n_s) begin
         sel_vec = 4'h0;
      end else begin
         sel_vec = 4'h1 << addr_hi_s;
      end
   end

   // lowest selected channel answers; single select on reads is assumed
   always_comb begin
      rd_idx = 2'h0;
      for (int i = 3; i >= 0; i--) begin
         if (sel_vec[i]) begin
            rd_idx = 2'(i);
         end
      end
   end

   assign wr_act = strobe_bus ? (!wr_n_s && |sel_vec) : (!cs_n_s && !rw_n_s);
   assign rd_act = strobe_bus ? (!rd_n_s && wr_n_s && |sel_vec) : (!cs_n_s && rw_n_s);
   assign commit = (state_reg == QHP_WRITE) && !wr_act;

   // ----------------------------------------------------------------
   // host cycle tracking
   // ----------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (!core_rst_n) begin
         state_reg <= QHP_IDLE;
      end else begin
         unique case (state_reg)
            QHP_IDLE: begin
               if (wr_act) begin
                  state_reg <= QHP_WRITE;
               end else if (rd_act) begin
                  state_reg <= QHP_READ;
               end
            end
            QHP_WRITE: begin
               if (!wr_act) begin
                  state_reg <= QHP_IDLE;
               end
            end
            QHP_READ: begin
               if (!rd_act) begin
                  state_reg <= QHP_IDLE;
               end
            end
         endcase
      end
   end

   // latest values seen while the strobe is active are the ones committed
   always_ff @(posedge CLK) begin
      if (!core_rst_n) begin
         wr_sel_reg <= 4'h0;
         wdata_reg <= 8'h00;
      end else if (wr_act) begin
         wr_sel_reg <= sel_vec;
         wdata_reg <= data_s;
      end
   end

   always_ff @(posedge CLK) begin
      if (!core_rst_n) begin
         addr_reg <= 3'h0;
         rd_idx_reg <= 2'h0;
      end else if (wr_act || rd_act) begin
         addr_reg <= addr_s;
         rd_idx_reg <= rd_idx;
      end
   end

   always_ff @(posedge CLK) begin
      if (!core_rst_n) begin
         CORE_WR_PULSE <= 4'h0;
         CORE_RD_PULSE <= 4'h0;
      end else begin
         CORE_WR_PULSE <= commit ? wr_sel_reg : 4'h0;
         CORE_RD_PULSE <= (state_reg == QHP_READ && !rd_act) ? (4'h1 << rd_idx_reg) : 4'h0;
      end
   end

   assign CORE_ADDR = addr_reg;
   assign CORE_WDATA = wdata_reg;

   // ----------------------------------------------------------------
   // per-channel control registers and status
   // ----------------------------------------------------------------
   for (genvar gi = 0; gi < 4; gi++) begin : g_chan
      qhp_chan_if ch_if ();

      always_ff @(posedge CLK) begin
         if (!core_rst_n) begin
            mcr_reg[gi] <= `QHP_MCR_RESET;
            fcr_reg[gi] <= `QHP_FCR_RESET;
         end else if (commit && wr_sel_reg[gi]) begin
            if (addr_reg == `QHP_MCR_ADDR) begin
               mcr_reg[gi] <= wdata_reg;
            end
            if (addr_reg == `QHP_FCR_ADDR) begin
               fcr_reg[gi] <= wdata_reg;
            end
         end else if (strap_load) begin
            mcr_reg[gi][`QHP_MCR_PRESCALE_BIT] <= pre_sel_s;
         end
      end

      assign ch_if.fifo_en = fcr_reg[gi][`QHP_FCR_FIFO_EN_BIT];
      assign ch_if.block_mode = fcr_reg[gi][`QHP_FCR_BLOCK_BIT];
      assign ch_if.rx_timeout = RX_TIMEOUT[gi];
      assign ch_if.tx_shift_empty = TX_SHIFT_EMPTY[gi];
      assign ch_if.tx_count = TX_COUNT[gi*7 +: 7];
      assign ch_if.rx_count = RX_COUNT[gi*7 +: 7];
      assign ch_if.tx_trig = TX_TRIG[gi*7 +: 7];
      assign ch_if.rx_trig = RX_TRIG[gi*7 +: 7];

      qhp_chan_status u_stat (
         .clk(CLK),
         .rst_n(core_rst_n),
         .ch(ch_if)
      );

      assign tx_rdy_n[gi] = ch_if.tx_ready_n;
      assign rx_rdy_n[gi] = ch_if.rx_ready_n;
      assign tx_int[gi] = ch_if.tx_int;
      assign rx_int[gi] = ch_if.rx_int;
      assign lsr_room[gi] = ch_if.lsr_room;
      assign lsr_empty[gi] = ch_if.lsr_empty;
      assign XON_ANY_ENABLE[gi] = mcr_reg[gi][`QHP_MCR_XON_ANY_BIT];
      assign PRESCALE_DIV4[gi] = mcr_reg[gi][`QHP_MCR_PRESCALE_BIT];

      always_ff @(posedge CLK) begin
         if (!core_rst_n) begin
            IRQ_OUT[gi] <= 1'b0;
            IRQ_OE[gi] <= 1'b0;
         end else begin
            IRQ_OUT[gi] <= tx_int[gi] || rx_int[gi];
            IRQ_OE[gi] <= !strobe_bus || irq_mode_s
               || mcr_reg[gi][`QHP_MCR_IRQ_EN_BIT];
         end
      end
   end

   assign TX_READY_N = tx_rdy_n;
   assign RX_READY_N = rx_rdy_n;

   // ----------------------------------------------------------------
   // ready summary and read data
   // ----------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (!core_rst_n) begin
         FIFO_READY_SUMMARY <= 8'hF0;
      end else begin
         FIFO_READY_SUMMARY <= {rx_rdy_n, tx_rdy_n};
      end
   end

   always_comb begin
      rd_mux = CORE_RD_DATA[rd_idx*8 +: 8];
      if (addr_s == `QHP_MCR_ADDR) begin
         rd_mux = mcr_reg[rd_idx];
      end else if (addr_s == `QHP_LSR_ADDR) begin
         rd_mux[`QHP_LSR_THR_ROOM_BIT] = lsr_room[rd_idx];
         rd_mux[`QHP_LSR_TX_EMPTY_BIT] = lsr_empty[rd_idx];
      end else if (addr_s == `QHP_FIFO_READY_SUMMARY_REG_ADDR) begin
         rd_mux = FIFO_READY_SUMMARY;
      end
   end

   always_ff @(posedge CLK) begin
      if (!core_rst_n) begin
         DATA_OUT <= 8'h00;
         DATA_OE <= 1'b0;
      end else begin
         DATA_OE <= rd_act;
         if (rd_act) begin
            DATA_OUT <= rd_mux;
         end
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   AST_WR_BROADCAST: assert property (@(posedge CLK) disable iff (!core_rst_n)
      commit |=> CORE_WR_PULSE == $past(wr_sel_reg))
      else $error("write pulse does not match the selected channels");
   AST_NO_SELECT: assert property (@(posedge CLK) disable iff (!core_rst_n)
      (state_reg == QHP_IDLE && strobe_bus && cs4_n_s == 4'hF) |=> state_reg == QHP_IDLE)
      else $error("cycle started with no channel selected");
   AST_RW_DECODE: assert property (@(posedge CLK) disable iff (!core_rst_n)
      (!strobe_bus && !cs_n_s && !rw_n_s) |=> wr_sel_reg == (4'h1 << $past(addr_hi_s)))
      else $error("extra address bits decoded to the wrong channel");
   AST_IRQ_DRIVE: assert property (@(posedge CLK) disable iff (!core_rst_n)
      (strobe_bus && !irq_mode_s && mcr_reg[0][`QHP_MCR_IRQ_EN_BIT] == 1'b0) [*2]
      |-> !IRQ_OE[0])
      else $error("interrupt driven although software enable is clear");
   AST_RESET_PULSE: assert property (@(posedge CLK) disable iff (!RSTN)
      pin_active [*4] |=> ##1 SERIAL_RESET)
      else $error("minimum reset pulse did not reset the channels");
   AST_STRAP: assert property (@(posedge CLK) disable iff (!core_rst_n)
      strap_load && !commit |=> PRESCALE_DIV4 == {4{$past(pre_sel_s)}})
      else $error("prescaler default not taken from the select pin");
   AST_SUMMARY: assert property (@(posedge CLK) disable iff (!core_rst_n)
      ##1 FIFO_READY_SUMMARY == {$past(rx_rdy_n), $past(tx_rdy_n)})
      else $error("ready summary does not follow the ready pins");
   AST_READ_ENABLE: assert property (@(posedge CLK) disable iff (!core_rst_n)
      rd_act |=> DATA_OE ##0 DATA_OUT == $past(rd_mux))
      else $error("read data not driven during a read cycle");
endmodule : qhp_host_port

// ---- tb/qhp_core_model.sv ----
`timescale 1ns/1ps
module qhp_core_model (
   input wire logic [2:0] CORE_ADDR,
   input wire logic [3:0] TIMEOUT_REQ,
   output logic [27:0] TX_TRIG,
   output logic [27:0] RX_TRIG,
   output logic [3:0] RX_TIMEOUT,
   output logic [3:0] TX_SHIFT_EMPTY,
   output logic [31:0] CORE_RD_DATA
);
   // ---------------------------------------------
   // idle channel cores: shifters empty, receive timeout on request
   // ---------------------------------------------
   assign TX_TRIG = {4{7'h08}};
   assign RX_TRIG = {4{7'h08}};
   assign RX_TIMEOUT = TIMEOUT_REQ;
   assign TX_SHIFT_EMPTY = 4'hF;
   // status offset reads zero so only the overlaid bits show
   assign CORE_RD_DATA = (CORE_ADDR == 3'h5) ? 32'h0 : {4{5'h00, CORE_ADDR}};
endmodule : qhp_core_model

// ---- tb/quad_uart_host_select_ready_pins_test.sv ----
`timescale 1ns/1ps
module quad_uart_host_select_ready_pins_test;
   import qhp_pkg::*;
   logic clk = 0, rstn = 0, sty = 1, rpin = 0, ims = 1, pds = 0;
   logic csn = 1, rwn = 1, rdn = 1, wrn = 1;
   logic [3:0] sel_n = 4'hF, pseen;
   logic [1:0] ahi = 0;
   logic [3:0] tmo = 4'h0;
   logic [2:0] adr = 0, caddr;
   logic [7:0] din = 0, dout, fsum, cwd, rd;
   logic [27:0] txc = 0, rxc = 0, txt, rxt;
   logic [3:0] irq, irqoe, txr, rxr, xon, pdiv, cwp, crp, rto, tse;
   logic doe, srst;
   logic [31:0] crd;
   int err_count = 0, total_checks = 0, c;
   always #5 clk = ~clk;
   qhp_core_model u_core (.CORE_ADDR(caddr), .TIMEOUT_REQ(tmo), .TX_TRIG(txt), .RX_TRIG(rxt),
      .RX_TIMEOUT(rto), .TX_SHIFT_EMPTY(tse), .CORE_RD_DATA(crd));
   qhp_host_port u_dut (.CLK(clk), .RSTN(rstn), .BUS_STYLE_SEL(sty), .RESET_PIN(rpin),
      .IRQ_MODE_SELECT_IN(ims), .PRESCALER_DEFAULT_SELECT_IN(pds),
      .CHAN_A_SELECT_N(sel_n[0]), .CHAN_B_SELECT_N(sel_n[1]), .CHAN_C_SELECT_N(sel_n[2]),
      .CHAN_D_SELECT_N(sel_n[3]), .CS_N(csn), .RW_N(rwn), .READ_STROBE_N(rdn),
      .WRITE_STROBE_N(wrn), .ADDR_HI(ahi), .ADDR(adr), .DATA_IN(din), .DATA_OUT(dout),
      .DATA_OE(doe), .IRQ_OUT(irq), .IRQ_OE(irqoe), .TX_READY_N(txr), .RX_READY_N(rxr),
      .FIFO_READY_SUMMARY(fsum), .XON_ANY_ENABLE(xon), .PRESCALE_DIV4(pdiv),
      .SERIAL_RESET(srst), .CORE_ADDR(caddr), .CORE_WDATA(cwd), .CORE_WR_PULSE(cwp),
      .CORE_RD_PULSE(crp), .TX_COUNT(txc), .RX_COUNT(rxc), .TX_TRIG(txt), .RX_TRIG(rxt),
      .RX_TIMEOUT(rto), .TX_SHIFT_EMPTY(tse), .CORE_RD_DATA(crd));
   // ---------------------------------------------
   // host bus tasks and comparison
   // ---------------------------------------------
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic wr(input logic [3:0] s, input logic [2:0] a, input logic [7:0] d);
      pseen = 4'h0;
      @(posedge clk);
      #1 sel_n = s;
      adr = a;
      din = d;
      wrn = 0;
      csn = 0;
      rwn = 0;
      repeat (4) @(posedge clk);
      #1 wrn = 1;
      csn = 1;
      rwn = 1;
      repeat (8) begin
         @(posedge clk);
         #1 pseen = pseen | cwp;
      end
      sel_n = 4'hF;
   endtask : wr
   task automatic rd_t(input logic [3:0] s, input logic [2:0] a);
      @(posedge clk);
      #1 sel_n = s;
      adr = a;
      rdn = 0;
      csn = 0;
      repeat (5) @(posedge clk);
      #1 rd = dout;
      chk("data_oe", 8'h01, {7'h00, doe});
      rdn = 1;
      csn = 1;
      pseen = 4'h0;
      repeat (5) begin
         @(posedge clk);
         #1 pseen = pseen | crp;
      end
      sel_n = 4'hF;
   endtask : rd_t
   task automatic wrap_up;
      if (err_count == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up
   // ---------------------------------------------
   // main sequence and watchdog
   // ---------------------------------------------
   initial begin
      #20000;
      err_count++;
      wrap_up;
   end
   initial begin
      c = $urandom(49376);
      pds = 1'($urandom % 2);
      c = int'($urandom % 4);
      repeat (12) @(posedge clk);
      #1 rstn = 1;
      repeat (5) @(posedge clk);
      #1 chk("div4", {4'h0, {4{pds}}}, {4'h0, pdiv});
      chk("irq_oe", 8'h0F, {4'h0, irqoe});
      wr(4'h0, 3'h4, 8'hA0);
      chk("wr_pulse", 8'h0F, {4'h0, pseen});
      chk("xon", 8'h0F, {4'h0, xon});
      chk("div4", 8'h0F, {4'h0, pdiv});
      chk("wdata", 8'hA0, cwd);
      chk("core_addr", 8'h04, {5'h00, caddr});
      rxc[7*c +: 7] = 7'h01;
      wr(~(4'h1 << c), 3'h4, 8'h00);
      chk("wr_pulse", {4'h0, 4'h1 << c}, {4'h0, pseen});
      chk("xon", {4'h0, ~(4'h1 << c)}, {4'h0, xon});
      chk("rx_ready", {4'h0, ~(4'h1 << c)}, {4'h0, rxr});
      chk("tx_ready", 8'h00, {4'h0, txr});
      rd_t(4'hE, 3'h7);
      chk("summary", {~(4'h1 << c), 4'h0}, rd);
      chk("summary_pin", {~(4'h1 << c), 4'h0}, fsum);
      chk("rd_pulse", 8'h01, {4'h0, pseen});
      rd_t(4'hE, 3'h5);
      chk("line_status", 8'h60, rd);
      wr(4'hF, 3'h4, 8'hFF);
      chk("wr_pulse", 8'h00, {4'h0, pseen});
      // fifo on: levels against the model's trigger of 8, then block mode
      wr(4'h0, 3'h2, 8'h01);
      txc = {4{7'h20}};
      rxc[7*c +: 7] = 7'(8 + $urandom % 8);
      repeat (3) @(posedge clk);
      #1 chk("irq", {4'h0, 4'h1 << c}, {4'h0, irq});
      chk("rx_ready", {4'h0, ~(4'h1 << c)}, {4'h0, rxr});
      chk("tx_ready", 8'h0F, {4'h0, txr});
      wr(4'h0, 3'h2, 8'h09);
      txc[7*c +: 7] = 7'h40;
      repeat (2) @(posedge clk);
      #1 chk("tx_ready", {4'h0, 4'h1 << c}, {4'h0, txr});
      rd_t(~(4'h1 << c), 3'h5);
      chk("line_status", 8'h00, rd);
      chk("rd_pulse", {4'h0, 4'h1 << c}, {4'h0, pseen});
      rxc[7*c +: 7] = 7'h01;
      repeat (2) @(posedge clk);
      #1 chk("rx_ready", {4'h0, ~(4'h1 << c)}, {4'h0, rxr});
      rxc[7*c +: 7] = 7'h00;
      repeat (2) @(posedge clk);
      #1 chk("rx_ready", 8'h0F, {4'h0, rxr});
      rxc[7*c +: 7] = 7'h01;
      tmo[c] = 1'b1;
      repeat (2) @(posedge clk);
      #1 chk("rx_ready", {4'h0, ~(4'h1 << c)}, {4'h0, rxr});
      tmo = 4'h0;
      ims = 0;
      repeat (4) @(posedge clk);
      #1 chk("irq_oe", 8'h00, {4'h0, irqoe});
      wr(4'h0, 3'h4, 8'h28);
      chk("irq_oe", 8'h0F, {4'h0, irqoe});
      rpin = 1;
      repeat (8) @(posedge clk);
      #1 rpin = 0;
      chk("serial_reset", 8'h01, {7'h00, srst});
      repeat (8) @(posedge clk);
      #1 chk("xon", 8'h00, {4'h0, xon});
      chk("serial_reset", 8'h00, {7'h00, srst});
      chk("div4", {4'h0, {4{pds}}}, {4'h0, pdiv});
      // read/write-line style: reset pin idles high
      sty = 0;
      rpin = 1;
      repeat (6) @(posedge clk);
      #1;
      for (int k = 0; k < 4; k++) begin
         ahi = k[1:0];
         wr(4'hF, 3'h4, 8'h20);
         chk("wr_pulse", {4'h0, 4'h1 << k}, {4'h0, pseen});
      end
      rpin = 0;
      repeat (8) @(posedge clk);
      #1 rpin = 1;
      repeat (8) @(posedge clk);
      #1 chk("xon", 8'h00, {4'h0, xon});
      chk("irq_oe", 8'h0F, {4'h0, irqoe});
      wrap_up;
   end
endmodule : quad_uart_host_select_ready_pins_test
